// File: hw/seq_gain_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "seq_gain_consts.svh"


module seq_gain_config
(
   // Clock and reset
   input  wire  logic                       ref_clk,
   input  wire  logic                       srst,
   // Register access from the serial interface
   input  wire  seq_gain_pkg::reg_req_t     regReq,
   output var   seq_gain_pkg::reg_rsp_t     regRsp,
   // Automatic gain control updates for step 0
   input  wire  logic                       agcActive,
   input  wire  logic                       agcWrEn,
   input  wire  seq_gain_pkg::step_gains_t  agcGains,
   // Configuration to the sequencer
   output var   seq_gain_pkg::all_gains_t   gainCode,
   output var   seq_gain_pkg::routes_t      step0Route,
   output var   seq_gain_pkg::factors_t     gainFactor,
   output var   seq_gain_pkg::conn_matrix_t diodeConn
);
   import seq_gain_pkg::*;

   typedef struct packed {
      all_gains_t gain;
      logic [7:0] routeLow;
      logic [3:0] routeHigh;
      reg_rsp_t   rsp;
   } cfg_state_t;

   cfg_state_t st_r;
   cfg_state_t st_nxt;

   function automatic logic isGainAddr(input logic [7:0] a);
      return (a >= `OFS_STEP0_GAIN_LOW) && (a <= `OFS_STEP3_GAIN_HIGH);
   endfunction

   // Step index and high/low select of a gain register address
   function automatic logic [2:0] gainSlot(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - `OFS_STEP0_GAIN_LOW;
      return rel[2:0];
   endfunction

   function automatic logic [7:0] readMux(input cfg_state_t s, input logic [7:0] a);
      logic [7:0] res;
      logic [2:0] slot;
      res  = 8'h00;
      slot = gainSlot(a);
      if (isGainAddr(a))
      begin
         if (slot[0])
            res = {4'h0, s.gain[slot[2:1]].mod2};
         else
            res = {s.gain[slot[2:1]].mod1, s.gain[slot[2:1]].mod0};
      end
      else if (a == `OFS_ROUTE_LOW)
      begin
         res = s.routeLow;
      end
      else if (a == `OFS_ROUTE_HIGH)
      begin
         res = {4'h0, s.routeHigh};
      end
      return res;
   endfunction

   always_comb
   begin
      logic [2:0] slot;
      slot = gainSlot(regReq.addr);
      st_nxt = st_r;
      st_nxt.rsp.valid = 1'b0;
      if (regReq.wrEn)
      begin
         if (isGainAddr(regReq.addr))
         begin
            if (slot[0])
            begin
               // Upper nibble dropped
               st_nxt.gain[slot[2:1]].mod2 = regReq.wrData[`MOD2_GAIN_LSB +: 4];
            end
            else
            begin
               st_nxt.gain[slot[2:1]].mod0 = regReq.wrData[`MOD0_GAIN_LSB +: 4];
               st_nxt.gain[slot[2:1]].mod1 = regReq.wrData[`MOD1_GAIN_LSB +: 4];
            end
         end
         else if (regReq.addr == `OFS_ROUTE_LOW)
         begin
            st_nxt.routeLow = regReq.wrData;
         end
         else if (regReq.addr == `OFS_ROUTE_HIGH)
         begin
            st_nxt.routeHigh = regReq.wrData[3:0];
         end
      end
      // Hardware update wins over a simultaneous software write
      if (agcActive && agcWrEn)
      begin
         st_nxt.gain[0] = agcGains;
      end
      if (regReq.rdEn)
      begin
         st_nxt.rsp.data  = readMux(st_r, regReq.addr);
         st_nxt.rsp.valid = 1'b1;
      end
      if (srst)
      begin
         st_nxt.gain      = {4{{`GAIN_RST, `GAIN_RST, `GAIN_RST}}};
         st_nxt.routeLow  = `ROUTE_LOW_RST;
         st_nxt.routeHigh = `ROUTE_HIGH_RST;
         st_nxt.rsp       = '0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      st_r <= st_nxt;
   end

   assign regRsp     = st_r.rsp;
   assign gainCode   = st_r.gain;
   assign step0Route = {st_r.routeHigh, st_r.routeLow};

   gain_route_decode u_decode
   (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .gains      (st_r.gain),
      .routes     ({st_r.routeHigh, st_r.routeLow}),
      .gainFactor (gainFactor),
      .diodeConn  (diodeConn)
   );

   // Checks
   logic agcHit;
   assign agcHit = agcActive && agcWrEn;

   a_gain_reset: assert property (@(posedge ref_clk)
      srst |=> (gainCode[3].mod2 == 4'h8) && (gainCode[0].mod0 == 4'h8)
               && (gainCode[2].mod1 == 4'h8))
      else $error("gain codes not 0x8 after reset");
   a_route_reset: assert property (@(posedge ref_clk)
      srst |=> (step0Route[3:0] == {2'h1, 2'h2, 2'h1, 2'h2}))
      else $error("step-0 routes not 0x66 after reset");
   a_route5_reset: assert property (@(posedge ref_clk)
      srst |=> (step0Route[5] == 2'h1) && (step0Route[4] == 2'h2))
      else $error("diode 4/5 routes wrong after reset");
   a_agc_update: assert property (@(posedge ref_clk) disable iff (srst)
      agcHit |=> (gainCode[0] == $past(agcGains)))
      else $error("gain control update not stored in step 0");
   a_agc_readback: assert property (@(posedge ref_clk) disable iff (srst)
      agcHit ##1 (regReq.rdEn && regReq.addr == 8'hD4 && !agcHit && !regReq.wrEn)
      |=> regRsp.valid && regRsp.data == {$past(agcGains.mod1, 2), $past(agcGains.mod0, 2)})
      else $error("gain control value not visible on read");
   a_low_write: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && regReq.addr == 8'hD8) |=>
      (gainCode[2].mod0 == $past(regReq.wrData[3:0]))
      && (gainCode[2].mod1 == $past(regReq.wrData[7:4])))
      else $error("step 2 low gain fields misplaced");
   a_high_write: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && regReq.addr == 8'hDB) |=>
      (gainCode[3].mod2 == $past(regReq.wrData[3:0])) && $stable(gainCode[3].mod0))
      else $error("step 3 high gain field misplaced");
   a_route_write: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && regReq.addr == 8'hDC) |=>
      (step0Route[3] == $past(regReq.wrData[7:6])) && (step0Route[0] == $past(regReq.wrData[1:0])))
      else $error("step-0 route fields misplaced");
   a_reserved_read: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.rdEn && regReq.addr inside {8'hD5, 8'hD7, 8'hD9, 8'hDB}) |=>
      regRsp.valid && (regRsp.data[7:4] == 4'h0))
      else $error("reserved gain bits not zero on read");
   a_gain_hold: assert property (@(posedge ref_clk) disable iff (srst)
      (!regReq.wrEn && !agcHit) |=> $stable(gainCode))
      else $error("gain codes changed without a write");
   a_route_high_write: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && regReq.addr == 8'hDD) |=>
      (step0Route[5] == $past(regReq.wrData[3:2]))
      && (step0Route[4] == $past(regReq.wrData[1:0])))
      else $error("diode 4/5 route fields misplaced");
   a_low_read: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.rdEn && regReq.addr == 8'hD4) |=>
      (regRsp.data == {$past(gainCode[0].mod1), $past(gainCode[0].mod0)}))
      else $error("step 0 low gain read misplaced");
   a_read_valid: assert property (@(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> (regRsp.valid == $past(regReq.rdEn)))
      else $error("read valid does not follow the read strobe");
   a_rsp_hold: assert property (@(posedge ref_clk) disable iff (srst)
      !regReq.rdEn |=> $stable(regRsp.data))
      else $error("read data changed without a read");
   a_route_hold: assert property (@(posedge ref_clk) disable iff (srst)
      !regReq.wrEn |=> $stable(step0Route))
      else $error("routes changed without a write");
   a_agc_ignored: assert property (@(posedge ref_clk) disable iff (srst)
      (agcWrEn && !agcActive && !regReq.wrEn) |=> $stable(gainCode[0]))
      else $error("gain control update taken while inactive");
   a_unmapped_write: assert property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && !(regReq.addr inside {[8'hD4:8'hDD]}) && !agcHit) |=>
      $stable(gainCode) && $stable(step0Route))
      else $error("write to an unmapped address changed a register");

   c_agc_update: cover property (@(posedge ref_clk) disable iff (srst) agcHit);
   c_route_write: cover property (@(posedge ref_clk) disable iff (srst)
      regReq.wrEn && regReq.addr == 8'hDC);
   c_write_then_read: cover property (@(posedge ref_clk) disable iff (srst)
      (regReq.wrEn && regReq.addr == 8'hD7) ##1 (regReq.rdEn && regReq.addr == 8'hD7));
   c_agc_ignored: cover property (@(posedge ref_clk) disable iff (srst)
      agcWrEn && !agcActive);
   c_route_high_write: cover property (@(posedge ref_clk) disable iff (srst)
      regReq.wrEn && regReq.addr == 8'hDD);

endmodule
`default_nettype wire

// File: hw/seq_gain_consts.svh
`ifndef SEQ_GAIN_CONSTS_SVH
`define SEQ_GAIN_CONSTS_SVH

// Register offsets
`define OFS_STEP0_GAIN_LOW   8'hD4
`define OFS_STEP0_GAIN_HIGH  8'hD5
`define OFS_STEP1_GAIN_LOW   8'hD6
`define OFS_STEP1_GAIN_HIGH  8'hD7
`define OFS_STEP2_GAIN_LOW   8'hD8
`define OFS_STEP2_GAIN_HIGH  8'hD9
`define OFS_STEP3_GAIN_LOW   8'hDA
`define OFS_STEP3_GAIN_HIGH  8'hDB
`define OFS_ROUTE_LOW        8'hDC
`define OFS_ROUTE_HIGH       8'hDD

// Field positions
`define MOD0_GAIN_LSB        0
`define MOD1_GAIN_LSB        4
`define MOD2_GAIN_LSB        0

// Reset values
`define GAIN_RST             4'h8
`define ROUTE_LOW_RST        8'h66
`define ROUTE_HIGH_RST       4'h6

// Highest defined gain code
`define GAIN_CODE_MAX        4'hD

`endif

// File: hw/seq_gain_pkg.sv
`default_nettype none
package seq_gain_pkg;

   typedef logic [3:0]  gain_code_t;
   typedef logic [1:0]  route_t;
   // Gain in units of one half
   typedef logic [13:0] gain_factor_t;
   // One-hot {modulator2, modulator1, modulator0}, zero when unconnected
   typedef logic [2:0]  conn_t;

   typedef struct packed {
      gain_code_t mod2;
      gain_code_t mod1;
      gain_code_t mod0;
   } step_gains_t;

   typedef step_gains_t  [3:0]      all_gains_t;
   typedef route_t       [5:0]      routes_t;
   typedef gain_factor_t [3:0][2:0] factors_t;
   typedef conn_t        [5:0]      conn_matrix_t;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } reg_rsp_t;

endpackage
`default_nettype wire

// File: hw/gain_route_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "seq_gain_consts.svh"

module gain_route_decode
(
   // Clock and reset
   input  wire  logic                       ref_clk,
   input  wire  logic                       srst,
   // Stored configuration
   input  wire  seq_gain_pkg::all_gains_t   gains,
   input  wire  seq_gain_pkg::routes_t      routes,
   // Decoded settings
   output var   seq_gain_pkg::factors_t     gainFactor,
   output var   seq_gain_pkg::conn_matrix_t diodeConn
);
   import seq_gain_pkg::*;

   typedef struct packed {
      factors_t     factor;
      conn_matrix_t conn;
   } dec_state_t;

   dec_state_t st_r;
   dec_state_t st_nxt;

   // Power of two in halves; undefined codes clamp to the top gain
   function automatic gain_factor_t codeToFactor(input gain_code_t code);
      gain_code_t c;
      c = (code > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX : code;
      return gain_factor_t'(14'h0001 << c);
   endfunction

   function automatic conn_t routeToConn(input route_t sel);
      conn_t res;
      case (sel)
         2'h0:    res = 3'h0;
         2'h1:    res = 3'h1;
         2'h2:    res = 3'h2;
         2'h3:    res = 3'h4;
         default: res = 3'h0;
      endcase
      return res;
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      for (int s = 0; s < 4; s++)
      begin
         st_nxt.factor[s][0] = codeToFactor(gains[s].mod0);
         st_nxt.factor[s][1] = codeToFactor(gains[s].mod1);
         st_nxt.factor[s][2] = codeToFactor(gains[s].mod2);
      end
      for (int d = 0; d < 6; d++)
      begin
         st_nxt.conn[d] = routeToConn(routes[d]);
      end
      if (srst)
      begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      st_r <= st_nxt;
   end

   assign gainFactor = st_r.factor;
   assign diodeConn  = st_r.conn;

   a_route_decode: assert property (@(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> (diodeConn[0] == (($past(routes[0]) == 2'h0) ? 3'h0 :
                        3'(3'h1 << ($past(routes[0]) - 2'h1)))))
      else $error("diode 0 connection does not follow its selector");
   a_route_onehot: assert property (@(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> $onehot0(diodeConn[3])
      && ((diodeConn[3] == 3'h0) == ($past(routes[3]) == 2'h0)))
      else $error("diode 3 connection not one-hot or wrongly unconnected");
   a_gain_factor: assert property (@(posedge ref_clk) disable iff (srst)
      !$past(srst) |->
      ($past(gains[1].mod1) != 4'h0 || gainFactor[1][1] == 14'h0001) &&
      ($past(gains[1].mod1) != 4'hD || gainFactor[1][1] == 14'h2000))
      else $error("gain code does not map to its power of two");

endmodule
`default_nettype wire

// File: testbench/seq_gain_config_test.sv
`timescale 1ns/1ps
`default_nettype none

module seq_gain_config_test;
   import seq_gain_pkg::*;

   logic         ref_clk = 1'b0;
   logic         srst = 1'b1;
   reg_req_t     regReq = '0;
   reg_rsp_t     regRsp;
   logic         agcActive = 1'b0;
   logic         agcWrEn = 1'b0;
   step_gains_t  agcGains = '0;
   all_gains_t   gainCode;
   routes_t      step0Route;
   factors_t     gainFactor;
   conn_matrix_t diodeConn;
   all_gains_t   gm;
   routes_t      rt;
   int           errors = 0;
   int           totalChecks = 0;
   int           cycles = 0;
   int           seed = 38;
   logic [7:0]   a;
   logic [7:0]   d;

   seq_gain_config i_dut
   (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .regReq     (regReq),
      .regRsp     (regRsp),
      .agcActive  (agcActive),
      .agcWrEn    (agcWrEn),
      .agcGains   (agcGains),
      .gainCode   (gainCode),
      .step0Route (step0Route),
      .gainFactor (gainFactor),
      .diodeConn  (diodeConn)
   );

   always #5 ref_clk = ~ref_clk;

   task automatic tally_and_finish();
      if (errors == 0 && totalChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected read value from the bench model
   function automatic logic [7:0] regv(input logic [7:0] ad);
      int n;
      n = (ad - 8'hD4) >> 1;
      if (ad >= 8'hD4 && ad <= 8'hDB)
         return ad[0] ? {4'h0, gm[n].mod2} : {gm[n].mod1, gm[n].mod0};
      if (ad == 8'hDC)
         return rt[3:0];
      if (ad == 8'hDD)
         return {4'h0, rt[5:4]};
      return 8'h00;
   endfunction

   function automatic void apply(input logic [7:0] ad, input logic [7:0] dt);
      int n;
      n = (ad - 8'hD4) >> 1;
      if (ad >= 8'hD4 && ad <= 8'hDB && !ad[0])
         {gm[n].mod1, gm[n].mod0} = dt;
      else if (ad >= 8'hD4 && ad <= 8'hDB)
         gm[n].mod2 = dt[3:0];
      else if (ad == 8'hDC)
         rt[3:0] = dt;
      else if (ad == 8'hDD)
         rt[5:4] = dt[3:0];
   endfunction

   function automatic logic [13:0] fac(input logic [3:0] c);
      return (c > 4'hD) ? 14'h2000 : (14'h1 << c);
   endfunction

   function automatic logic [2:0] conn(input logic [1:0] s);
      return (s == 2'h0) ? 3'h0 : (3'h1 << (s - 2'h1));
   endfunction

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge ref_clk);
      regReq <= {1'b1, 1'b0, ad, dt};
      @(posedge ref_clk);
      regReq <= '0;
      #1;
   endtask

   task automatic rd(input logic [7:0] ad);
      @(posedge ref_clk);
      regReq <= {1'b0, 1'b1, ad, 8'h00};
      @(posedge ref_clk);
      regReq <= '0;
      #1;
      check(regRsp.valid, 1'b1);
      check(regRsp.data, regv(ad));
      @(posedge ref_clk);
      #1;
      check(regRsp.valid, 1'b0);
   endtask

   // Stored outputs now, decoded outputs one cycle later
   task automatic chk_all();
      check(gainCode, gm);
      check(step0Route, rt);
      @(posedge ref_clk);
      #1;
      for (int s = 0; s < 4; s++)
         for (int m = 0; m < 3; m++)
            check(gainFactor[s][m], fac(gm[s][4*m +: 4]));
      for (int i = 0; i < 6; i++)
         check(diodeConn[i], conn(rt[i]));
   endtask

   initial
   begin
      gm = {4{12'h888}};
      rt = {2'h1, 2'h2, 8'h66};
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      chk_all();
      for (int i = 0; i < 11; i++)
         rd(8'hD4 + i[7:0]);
      // All four selector codes across diodes 0 to 3, then codes 0, D and clamp
      wr(8'hDC, 8'hE4);
      apply(8'hDC, 8'hE4);
      chk_all();
      wr(8'hDC, 8'h1B);
      apply(8'hDC, 8'h1B);
      chk_all();
      wr(8'hD6, 8'hD0);
      apply(8'hD6, 8'hD0);
      wr(8'hD7, 8'hFF);
      apply(8'hD7, 8'hFF);
      chk_all();
      rd(8'hD7);
      wr(8'hDD, 8'hF9);
      apply(8'hDD, 8'hF9);
      chk_all();
      rd(8'hDD);
      wr(8'hD3, 8'h55);
      rd(8'hD3);
      chk_all();
      // Gain control ignored while inactive, taken while active
      @(posedge ref_clk);
      agcWrEn <= 1'b1;
      agcGains <= 12'h123;
      @(posedge ref_clk);
      agcWrEn <= 1'b0;
      #1;
      chk_all();
      @(posedge ref_clk);
      agcActive <= 1'b1;
      agcWrEn <= 1'b1;
      // Same-cycle software write to step 0 loses to gain control
      regReq <= {1'b1, 1'b0, 8'hD4, 8'h99};
      @(posedge ref_clk);
      agcWrEn <= 1'b0;
      agcActive <= 1'b0;
      regReq <= {1'b0, 1'b1, 8'hD4, 8'h00};
      @(posedge ref_clk);
      regReq <= '0;
      #1;
      gm[0] = 12'h123;
      check(regRsp.valid, 1'b1);
      check(regRsp.data, regv(8'hD4));
      chk_all();
      rd(8'hD4);
      rd(8'hD5);
      for (int k = 0; k < 60; k++)
      begin
         a = 8'hD4 + 8'($unsigned($random(seed)) % 11);
         d = 8'($random(seed));
         wr(a, d);
         apply(a, d);
         chk_all();
         rd(8'hD4 + 8'($unsigned($random(seed)) % 11));
      end
      // Reset again after traffic
      @(posedge ref_clk);
      srst <= 1'b1;
      @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      gm = {4{12'h888}};
      rt = {2'h1, 2'h2, 8'h66};
      chk_all();
      rd(8'hDD);
      tally_and_finish();
   end

endmodule

`default_nettype wire
